/* File: core/lsw_core.v */
/*
  LIN sleep, wakeup and frame classification control.
  Assumes an external frame decoder delivering checked identifiers,
  break detection and errors; bus pins are synchronous to CLOCK.
*/
`timescale 1ns/10ps
`include "lsw_map.vh"
module lsw_core #(
  parameter IDLE_MS = `LSW_MS_IDLE,
  parameter LONG_MS = `LSW_MS_LONG,
  parameter RETRY_MS = `LSW_MS_RETRY,
  parameter READY_MS = `LSW_MS_READY,
  parameter WAKE_US = `LSW_US_WAKE,
  parameter US_DIV = `LSW_CLK_MHZ,
  parameter MS_DIV = `LSW_US_PER_MS
) (
  input wire CLOCK,
  input wire RSTN,
  input wire MASTER_MODE,
  input wire SLEEP_SET,
  input wire WAKE_REQ,
  input wire BUS_RX,
  input wire BREAK_SEEN,
  input wire HDR_VALID,
  input wire [5:0] HDR_ID,
  input wire HDR_EVENT,
  input wire HDR_SPORADIC,
  input wire RESP_DONE,
  input wire [3:0] RESP_LEN,
  input wire [7:0] RESP_BYTE0,
  input wire RESP_ERR,
  input wire RESP_COLLIDE,
  input wire DATA_UPDATED,
  input wire [5:0] OWN_ID,
  output reg BUS_TX_DOM,
  output reg SLEEPING,
  output reg READY,
  output reg IGNORE_BUS,
  output reg RESPOND_EN,
  output reg [7:0] RESP_PID,
  output reg POLL_SINGLE,
  output reg HDR_PERMIT,
  output reg [2:0] FRAME_CLASS,
  output reg EVT_VALID,
  output reg [7:0] EVT_CODE,
  output reg GOTO_SLEEP_SEEN
);
  // Wakeup state codes
  localparam ST_AWAKE = 3'h0;
  localparam ST_PULSE = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_LONG = 3'h3;
  localparam ST_ASLEEP = 3'h4;
  localparam ST_SETTLE = 3'h5;

  // Microsecond and millisecond enables
  wire us_tick;
  reg ms_tick;
  reg [9:0] us_cnt;
  // State and counters
  reg [2:0] state;
  reg [12:0] t_us;
  reg [12:0] t_ms;
  reg [1:0] tries;
  reg [12:0] idle_ms;
  reg idle_posted;
  reg [12:0] dom_us;
  reg sync_lost;
  reg hdr_mreq; // Open frame is a master request
  // Protected identifier of own unconditional frame
  wire p0 = OWN_ID[0] ^ OWN_ID[1] ^ OWN_ID[2] ^ OWN_ID[4];
  wire p1 = ~(OWN_ID[1] ^ OWN_ID[3] ^ OWN_ID[4] ^ OWN_ID[5]);
  wire [7:0] own_pid = {p1, p0, OWN_ID};

  lsw_tick #(
    .DIV(US_DIV)
  ) u_tick (
    .clk(CLOCK),
    .rstn(RSTN),
    .tick(us_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Millisecond enable from microsecond ticks
  always @(posedge CLOCK) begin
    if (!RSTN) begin
      us_cnt <= 10'h000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= 1'b0;
      if (us_tick) begin
        if (us_cnt == MS_DIV[9:0] - 10'h001) begin
          us_cnt <= 10'h000;
          ms_tick <= 1'b1;
        end else begin
          us_cnt <= us_cnt + 10'h001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus inactivity timer, restarted by any dominant level
  always @(posedge CLOCK) begin
    if (!RSTN) begin
      idle_ms <= 13'h0000;
      idle_posted <= 1'b0;
    end else if (!BUS_RX || SLEEPING) begin
      idle_ms <= 13'h0000;
      idle_posted <= 1'b0;
    end else if (ms_tick && idle_ms != IDLE_MS[12:0]) begin
      idle_ms <= idle_ms + 13'h0001;
    end else if (idle_ms == IDLE_MS[12:0] && !idle_posted) begin
      idle_posted <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Dominant width meter, used to recognise a remote wakeup
  always @(posedge CLOCK) begin
    if (!RSTN) begin
      dom_us <= 13'h0000;
    end else if (BUS_RX) begin
      dom_us <= 13'h0000;
    end else if (us_tick && dom_us != 13'h1FFF) begin
      dom_us <= dom_us + 13'h0001;
    end
  end
  // Remote wakeup seen when a long dominant pulse ends
  wire wake_rx = BUS_RX && (dom_us >= WAKE_US[12:0]) &&
                 (state == ST_ASLEEP);

  ////////////////////////////////////////////////////////////////////////
  // Sleep and wakeup sequencer; master and slave share one timing
  always @(posedge CLOCK) begin
    if (!RSTN) begin
      state <= ST_AWAKE;
      t_us <= 13'h0000;
      t_ms <= 13'h0000;
      tries <= 2'h0;
      SLEEPING <= 1'b0;
      READY <= 1'b1;
      BUS_TX_DOM <= 1'b0;
    end else begin
      case (state)
        ST_AWAKE: begin
          // Only host control puts the node to sleep
          if (SLEEP_SET) begin
            state <= ST_ASLEEP;
            SLEEPING <= 1'b1;
            READY <= 1'b0;
          end
        end
        ST_ASLEEP: begin
          if (WAKE_REQ) begin
            state <= ST_PULSE;
            t_us <= 13'h0000;
            tries <= 2'h0;
            BUS_TX_DOM <= 1'b1;
          end else if (wake_rx) begin
            state <= ST_SETTLE;
            t_ms <= 13'h0000;
          end
        end
        ST_PULSE: begin
          // Dominant pulse held a fixed, legal width
          if (us_tick) begin
            t_us <= t_us + 13'h0001;
          end
          if (t_us == WAKE_US[12:0] + `LSW_US_PAD) begin
            BUS_TX_DOM <= 1'b0;
            state <= ST_WAIT;
            t_ms <= 13'h0000;
            tries <= tries + 2'h1;
            SLEEPING <= 1'b0;
          end
        end
        ST_SETTLE: begin
          // Become ready one millisecond inside the allowed window
          SLEEPING <= 1'b0;
          if (ms_tick) begin
            t_ms <= t_ms + 13'h0001;
          end
          if (t_ms == READY_MS[12:0] - 13'h0001) begin
            READY <= 1'b1;
            state <= ST_AWAKE;
          end
        end
        ST_WAIT: begin
          READY <= 1'b1;
          if (ms_tick) begin
            t_ms <= t_ms + 13'h0001;
          end
          if (HDR_VALID || BREAK_SEEN) begin
            state <= ST_AWAKE;
          end else if (t_ms == RETRY_MS[12:0]) begin
            t_ms <= 13'h0000;
            if (tries == `LSW_TRIES) begin
              state <= ST_LONG;
            end else begin
              state <= ST_PULSE;
              t_us <= 13'h0000;
              BUS_TX_DOM <= 1'b1;
            end
          end
        end
        ST_LONG: begin
          if (ms_tick) begin
            t_ms <= t_ms + 13'h0001;
          end
          if (HDR_VALID || BREAK_SEEN) begin
            state <= ST_AWAKE;
          end else if (t_ms == LONG_MS[12:0]) begin
            state <= ST_PULSE;
            t_us <= 13'h0000;
            tries <= 2'h0;
            BUS_TX_DOM <= 1'b1;
          end
        end
        default: begin
          state <= ST_AWAKE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Master header permission: held off until slaves are ready after a remote wakeup, but only until the pulse ends after a local one
  always @(posedge CLOCK) begin
    if (!RSTN) begin
      HDR_PERMIT <= 1'b1;
    end else if (!MASTER_MODE) begin
      HDR_PERMIT <= 1'b0;
    end else if (state == ST_SETTLE) begin
      HDR_PERMIT <= 1'b0;
    end else begin
      HDR_PERMIT <= READY && !SLEEPING;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error confinement: drop the frame until the next break
  always @(posedge CLOCK) begin
    if (!RSTN) begin
      sync_lost <= 1'b0;
    end else if (RESP_ERR) begin
      // An error in the break cycle wins; the frame is still suspect
      sync_lost <= 1'b1;
    end else if (BREAK_SEEN) begin
      sync_lost <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame classification, response decisions and host events
  always @(posedge CLOCK) begin
    if (!RSTN) begin
      FRAME_CLASS <= `LSW_CLS_UNC;
      RESPOND_EN <= 1'b0;
      RESP_PID <= 8'h00;
      hdr_mreq <= 1'b0;
      POLL_SINGLE <= 1'b0;
      EVT_VALID <= 1'b0;
      EVT_CODE <= 8'h00;
      GOTO_SLEEP_SEEN <= 1'b0;
      IGNORE_BUS <= 1'b0;
    end else begin
      EVT_VALID <= 1'b0;
      GOTO_SLEEP_SEEN <= 1'b0;
      // Raised from the erroring edge so the host sees it at once
      IGNORE_BUS <= RESP_ERR || (sync_lost && !BREAK_SEEN);
      if (BREAK_SEEN) begin
        POLL_SINGLE <= POLL_SINGLE && !MASTER_MODE ? 1'b0 : POLL_SINGLE;
      end
      if (HDR_VALID && !sync_lost) begin
        // Header from master task opens the frame
        RESPOND_EN <= 1'b0;
        RESP_PID <= own_pid;
        hdr_mreq <= HDR_ID == `LSW_ID_MREQ;
        if (HDR_ID == `LSW_ID_RSVD) begin
          FRAME_CLASS <= `LSW_CLS_RSVD;
        end else if (HDR_ID == `LSW_ID_USER) begin
          FRAME_CLASS <= `LSW_CLS_USER;
          RESPOND_EN <= 1'b1;
        end else if (HDR_ID == `LSW_ID_MREQ ||
                     HDR_ID == `LSW_ID_SRESP) begin
          FRAME_CLASS <= `LSW_CLS_DIAG;
          RESPOND_EN <= HDR_ID == `LSW_ID_SRESP;
        end else if (HDR_EVENT) begin
          FRAME_CLASS <= `LSW_CLS_EVT;
          RESPOND_EN <= DATA_UPDATED;
        end else if (HDR_SPORADIC) begin
          FRAME_CLASS <= `LSW_CLS_SPO;
          RESPOND_EN <= MASTER_MODE && DATA_UPDATED;
        end else if (HDR_ID <= `LSW_ID_UNC_MAX) begin
          FRAME_CLASS <= `LSW_CLS_UNC;
          RESPOND_EN <= HDR_ID == OWN_ID;
        end
        if (MASTER_MODE) begin
          EVT_VALID <= 1'b1;
          EVT_CODE <= `LSW_CODE_HDR;
        end
      end else if (RESP_DONE && !sync_lost && !RESP_ERR) begin
        RESPOND_EN <= 1'b0;
        if (FRAME_CLASS == `LSW_CLS_EVT && RESP_COLLIDE) begin
          EVT_VALID <= 1'b1;
          EVT_CODE <= `LSW_CODE_BERR;
          POLL_SINGLE <= MASTER_MODE;
        end else if (FRAME_CLASS == `LSW_CLS_DIAG &&
                     RESP_LEN != `LSW_DIAG_LEN) begin
          EVT_VALID <= 1'b1;
          EVT_CODE <= `LSW_CODE_BERR;
        end else begin
          EVT_VALID <= 1'b1;
          EVT_CODE <= `LSW_CODE_FULL;
          // Identifier input is only valid with the header: use the copy
          if (hdr_mreq && RESP_BYTE0 == `LSW_SLEEP_BYTE) begin
            GOTO_SLEEP_SEEN <= 1'b1;
          end
        end
      end else if (RESP_ERR || RESP_COLLIDE) begin
        RESPOND_EN <= 1'b0;
        EVT_VALID <= 1'b1;
        EVT_CODE <= `LSW_CODE_BERR;
        if (RESP_COLLIDE && FRAME_CLASS == `LSW_CLS_EVT) begin
          POLL_SINGLE <= MASTER_MODE;
        end
      end else if (wake_rx) begin
        EVT_VALID <= 1'b1;
        EVT_CODE <= `LSW_CODE_WAKE;
      end else if (idle_ms == IDLE_MS[12:0] && !idle_posted) begin
        EVT_VALID <= 1'b1;
        EVT_CODE <= `LSW_CODE_IDLE;
      end
    end
  end
endmodule

/* File: core/lsw_map.vh */
/*
  Constants for the LIN sleep, wakeup and frame classifier block.
  Assumes a 100 MHz clock and a frame decoder that hands over each
  checked identifier and first data byte.
*/
`ifndef LSW_MAP_VH
`define LSW_MAP_VH
`define LSW_CLK_MHZ 100
`define LSW_ID_MREQ 6'h3C
`define LSW_ID_SRESP 6'h3D
`define LSW_ID_USER 6'h3E
`define LSW_ID_RSVD 6'h3F
`define LSW_ID_UNC_MAX 6'h3B
`define LSW_DIAG_LEN 4'h8
`define LSW_CODE_RESP 8'h10
`define LSW_CODE_HDR 8'h11
`define LSW_CODE_FULL 8'h12
`define LSW_CODE_WAKE 8'h13
`define LSW_CODE_IDLE 8'h14
`define LSW_CODE_BERR 8'h15
`define LSW_CLS_UNC 3'h0
`define LSW_CLS_EVT 3'h1
`define LSW_CLS_SPO 3'h2
`define LSW_CLS_DIAG 3'h3
`define LSW_CLS_USER 3'h4
`define LSW_CLS_RSVD 3'h5
`define LSW_US_WAKE 250
`define LSW_US_WAKE_MAX 5000
`define LSW_MS_READY 100
`define LSW_MS_RETRY 150
`define LSW_MS_LONG 1500
`define LSW_MS_IDLE 4000
`define LSW_TRIES 2'h3
`define LSW_US_PAD 13'h0032
`define LSW_US_PER_MS 1000
`define LSW_SLEEP_BYTE 8'h00
`endif

/* File: core/lsw_tick.v */
/*
  Divider that produces a one-cycle pulse every DIV clocks.
  Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module lsw_tick #(
  parameter DIV = 100
) (
  input wire clk,
  input wire rstn,
  output reg tick
);
  // Counter for the divider
  reg [19:0] cnt;

  ////////////////////////////////////////////////////////////////////////
  // Count up and emit a pulse at terminal value
  always @(posedge clk) begin
    if (!rstn) begin
      cnt <= 20'h00000;
      tick <= 1'b0;
    end else if (cnt == DIV[19:0] - 20'h00001) begin
      cnt <= 20'h00000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 20'h00001;
      tick <= 1'b0;
    end
  end
endmodule

/* File: test/lin_sleep_wakeup_frame_control_tb.sv */
/* Bench for lsw_core: classes, errors, events, sleep and wakeup.
   Assumes scaled dividers: 2 clocks per us, 8 clocks per ms. */
`timescale 1ns/10ps
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin \
  n_mismatch++; $display("mismatch %s exp %0h got %0h", nm, e, a); end end
module lin_sleep_wakeup_frame_control_tb;
  localparam int CPM = 8; // Clocks per scaled millisecond
  int total_checks = 0, n_mismatch = 0;
  logic clk = 0, rstn = 0, master_mode = 0, sleep_set = 0, wake_req = 0;
  logic break_seen = 0, hdr_valid = 0, hdr_event = 0, hdr_sporadic = 0;
  logic resp_done = 0, resp_err = 0, resp_collide = 0, data_updated = 0;
  logic [5:0] hdr_id = 6'h00, own_id = 6'h15;
  logic [3:0] resp_len = 4'h8;
  logic [7:0] resp_byte0 = 8'h00, resp_pid, evt_code;
  logic [2:0] frame_class;
  logic bus_rx, bus_tx_dom, sleeping, ready, ignore_bus, respond_en;
  logic poll_single, hdr_permit, evt_valid, goto_sleep_seen;
  //////////////////////////////////////////////////////////////////////////
  lsw_core #(.IDLE_MS(150), .LONG_MS(80), .RETRY_MS(30), .READY_MS(20),
    .WAKE_US(20), .US_DIV(2), .MS_DIV(4)) uut (.CLOCK(clk), .RSTN(rstn),
    .MASTER_MODE(master_mode), .SLEEP_SET(sleep_set), .WAKE_REQ(wake_req),
    .BUS_RX(bus_rx), .BREAK_SEEN(break_seen), .HDR_VALID(hdr_valid),
    .HDR_ID(hdr_id), .HDR_EVENT(hdr_event), .HDR_SPORADIC(hdr_sporadic),
    .RESP_DONE(resp_done), .RESP_LEN(resp_len), .RESP_BYTE0(resp_byte0),
    .RESP_ERR(resp_err), .RESP_COLLIDE(resp_collide),
    .DATA_UPDATED(data_updated), .OWN_ID(own_id), .BUS_TX_DOM(bus_tx_dom),
    .SLEEPING(sleeping), .READY(ready), .IGNORE_BUS(ignore_bus),
    .RESPOND_EN(respond_en), .RESP_PID(resp_pid), .POLL_SINGLE(poll_single),
    .HDR_PERMIT(hdr_permit), .FRAME_CLASS(frame_class),
    .EVT_VALID(evt_valid), .EVT_CODE(evt_code),
    .GOTO_SLEEP_SEEN(goto_sleep_seen));
  lsw_node node (.clk(clk), .tx_dom(bus_tx_dom), .rx(bus_rx));
  initial forever #5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  // Break and sync, then the identifier; returns one edge later
  task automatic hdr(input logic [5:0] id, input logic ev, input logic sp);
    break_seen = 1;
    @(negedge clk) break_seen = 0;
    hdr_id = id;
    hdr_event = ev;
    hdr_sporadic = sp;
    hdr_valid = 1;
    @(negedge clk) hdr_valid = 0;
  endtask
  // Waits for one event entry of the given code, bounded
  task automatic wait_evt(input logic [7:0] code, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge clk);
      if (evt_valid === 1'h1 && evt_code === code) break;
    end
    `CHK("evt", 1'h1, i < lim)
  endtask
  task automatic to_sleep();
    sleep_set = 1;
    @(negedge clk) sleep_set = 0;
    `CHK("sleeping", 1'h1, sleeping)
  endtask
  task automatic t_cls();
    logic [5:0] ids[8] = '{6'h00, 6'h05, 6'h07, 6'h3B, 6'h3C, 6'h3D,
      6'h3E, 6'h3F};
    logic [2:0] cls[8] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h3, 3'h3, 3'h4, 3'h5};
    for (int i = 0; i < 8; i++) begin
      hdr(ids[i], i == 1, i == 2);
      `CHK("class", cls[i], frame_class)
    end
    $display("end t_cls");
  endtask
  // Header after an error is dropped until the next break
  task automatic t_err();
    resp_err = 1;
    @(negedge clk) resp_err = 0;
    hdr_id = 6'h3E;
    hdr_valid = 1;
    @(negedge clk) hdr_valid = 0;
    `CHK("ignore", 1'h1, ignore_bus)
    `CHK("kept", 3'h5, frame_class)
    hdr(6'h3E, 0, 0);
    `CHK("user", 3'h4, frame_class)
    $display("end t_err");
  endtask
  task automatic t_evt();
    hdr(6'h05, 1, 0);
    `CHK("stale", 1'h0, respond_en)
    data_updated = 1;
    hdr(6'h05, 1, 0);
    `CHK("answer", 1'h1, respond_en)
    `CHK("pid", 8'h55, resp_pid)
    master_mode = 1;
    hdr(6'h05, 1, 0);
    resp_collide = 1;
    wait_evt(8'h15, 5);
    resp_collide = 0;
    `CHK("poll", 1'h1, poll_single)
    master_mode = 0;
    own_id = 6'h3A;
    hdr(6'h3A, 0, 0);
    `CHK("own", 1'h1, respond_en)
    `CHK("pid2", 8'hBA, resp_pid)
    $display("end t_evt");
  endtask
  // Response end; counts sleep pulses and keeps the last event code
  task automatic resp(input logic [3:0] len, input logic [7:0] b0,
    output int seen, output logic [7:0] code);
    seen = 0;
    code = 8'h00;
    resp_len = len;
    resp_byte0 = b0;
    resp_done = 1;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk) resp_done = 0;
      seen += (goto_sleep_seen === 1'h1);
      if (evt_valid === 1'h1) code = evt_code;
    end
  endtask
  // Sleep command is reported, sleep waits for the host
  task automatic t_gts();
    int seen;
    logic [7:0] code;
    hdr(6'h3C, 0, 0);
    hdr_id = 6'h01; // Identifier input is stale after the header
    resp(4'h8, 8'h00, seen, code);
    `CHK("gts", 1, seen)
    `CHK("full", 8'h12, code)
    `CHK("awake", 1'h0, sleeping)
    hdr(6'h3C, 0, 0);
    resp(4'h8, 8'h01, seen, code);
    `CHK("gts_data", 0, seen)
    hdr(6'h3C, 0, 0);
    resp(4'h7, 8'h00, seen, code);
    `CHK("diag_len", 8'h15, code)
    `CHK("gts_len", 0, seen)
    to_sleep();
    $display("end t_gts");
  endtask
  // Remote wakeup as master: headers held until slaves are ready
  task automatic t_rwake();
    master_mode = 1;
    node.wake(120);
    repeat (4) @(negedge clk);
    `CHK("held", 1'h0, hdr_permit)
    repeat (20 * CPM - 4) @(negedge clk);
    `CHK("ready", 2'h2, {ready, sleeping})
    `CHK("permit", 1'h1, hdr_permit)
    master_mode = 0;
    $display("end t_rwake");
  endtask
  // Local wakeup with no header: three pulses then the long wait
  task automatic t_wake(input logic m);
    int n, w = 0, gap[4];
    master_mode = m;
    to_sleep();
    wake_req = 1;
    @(negedge clk) wake_req = 0;
    for (int k = 0; k < 4; k++) begin
      for (n = 0; bus_tx_dom !== 1'h1 && n < 2000; n++) @(negedge clk);
      gap[k] = n + w;
      for (w = 0; bus_tx_dom === 1'h1 && w < 20000; w++) @(negedge clk);
      `CHK("width", 1'h1, w >= 40 && w <= 10000)
    end
    `CHK("retry", 1'h1, gap[1] >= 30 * CPM && gap[2] < 80 * CPM)
    `CHK("long", 1'h1, gap[3] >= 80 * CPM)
    hdr(6'h01, 0, 0);
    `CHK("permit", m, hdr_permit)
    master_mode = 0;
    $display("end t_wake");
  endtask
  task automatic t_idle();
    wait_evt(8'h14, 160 * CPM);
    `CHK("idle_awake", 1'h0, sleeping)
    $display("end t_idle");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the roughly 5000 cycles of the tests
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (12) @(negedge clk);
    `CHK("reset", 3'h6, {ready, hdr_permit, sleeping})
    rstn = 1;
    @(negedge clk);
    `CHK("slave_permit", 1'h0, hdr_permit)
    t_cls();
    t_err();
    t_evt();
    t_gts();
    t_rwake();
    t_wake(0);
    t_wake(1);
    t_idle();
    finish_test();
  end
endmodule

/* File: test/lsw_core_assertions.sv */
/* Port checker for lsw_core: frame classes, sleep and wakeup timing.
   Assumes the bind below attaches it to every lsw_core instance. */
`timescale 1ns/10ps
module lsw_chk #(
  parameter WAKE_US = 250,
  parameter US_DIV = 100
) (
  input logic CLOCK,
  input logic RSTN,
  input logic MASTER_MODE,
  input logic SLEEP_SET,
  input logic BREAK_SEEN,
  input logic HDR_VALID,
  input logic [5:0] HDR_ID,
  input logic HDR_EVENT,
  input logic HDR_SPORADIC,
  input logic RESP_ERR,
  input logic RESP_COLLIDE,
  input logic DATA_UPDATED,
  input logic [5:0] OWN_ID,
  input logic BUS_TX_DOM,
  input logic SLEEPING,
  input logic IGNORE_BUS,
  input logic RESPOND_EN,
  input logic [7:0] RESP_PID,
  input logic POLL_SINGLE,
  input logic [2:0] FRAME_CLASS,
  input logic EVT_VALID,
  input logic [7:0] EVT_CODE,
  input logic GOTO_SLEEP_SEEN
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // Frame inputs are dropped from an error until the next break
  logic lost;
  wire ok = !lost;
  wire hv = HDR_VALID && ok;
  always @(posedge CLOCK) begin
    if (!RSTN) lost <= 1'b0;
    else if (RESP_ERR) lost <= 1'b1;
    else if (BREAK_SEEN) lost <= 1'b0;
  end
  int unsigned dom_n; // Cycles of our own dominant drive
  //////////////////////////////////////////////////////////////////////////
  // Width counter; cleared whenever our own drive (BUS_TX_DOM) is released
  always @(posedge CLOCK) begin
    if (!RSTN || !BUS_TX_DOM) dom_n <= 0;
    else dom_n <= dom_n + 1;
  end
  a_unc_class: assert property (hv && HDR_ID <= 6'h3B && !HDR_EVENT
    && !HDR_SPORADIC |=> FRAME_CLASS == 3'h0) else $error("unc class");
  a_diag_class: assert property (hv && HDR_ID == 6'h3C
    |=> FRAME_CLASS == 3'h3) else $error("diag class");
  a_user_class: assert property (hv && HDR_ID == 6'h3E
    |=> FRAME_CLASS == 3'h4) else $error("user class");
  a_host_sleep: assert property ($rose(SLEEPING)
    |-> $past(SLEEP_SET) || $past(SLEEP_SET, 2)) else $error("self sleep");
  a_wake_width: assert property ($fell(BUS_TX_DOM)
    |-> dom_n >= WAKE_US * US_DIV && dom_n <= 5000 * US_DIV)
    else $error("wake width");
  a_evt_code: assert property (EVT_VALID
    |-> EVT_CODE inside {[8'h10:8'h15]}) else $error("evt code");
  a_pid_bits: assert property (RESPOND_EN |-> RESP_PID == {
    ~(OWN_ID[1] ^ OWN_ID[3] ^ OWN_ID[4] ^ OWN_ID[5]),
    OWN_ID[0] ^ OWN_ID[1] ^ OWN_ID[2] ^ OWN_ID[4], OWN_ID})
    else $error("pid bits");
  a_evt_quiet: assert property (hv && HDR_EVENT && !DATA_UPDATED
    && HDR_ID <= 6'h3B |=> !RESPOND_EN) else $error("stale answer");
  a_collide_poll: assert property (RESP_COLLIDE && MASTER_MODE
    && FRAME_CLASS == 3'h1 |=> ##[0:1] POLL_SINGLE)
    else $error("no poll");
  a_err_ignore: assert property (RESP_ERR && !SLEEPING
    && !BREAK_SEEN |=> IGNORE_BUS[*2]) else $error("error not held");
  c_wake: cover property ($fell(BUS_TX_DOM));
  c_poll: cover property ($rose(POLL_SINGLE));
  c_gts: cover property (GOTO_SLEEP_SEEN);
endmodule
bind lsw_core lsw_chk #(.WAKE_US(WAKE_US), .US_DIV(US_DIV)) chk (
  .CLOCK(CLOCK), .RSTN(RSTN), .MASTER_MODE(MASTER_MODE),
  .SLEEP_SET(SLEEP_SET), .BREAK_SEEN(BREAK_SEEN), .HDR_VALID(HDR_VALID),
  .HDR_ID(HDR_ID), .HDR_EVENT(HDR_EVENT), .HDR_SPORADIC(HDR_SPORADIC),
  .RESP_ERR(RESP_ERR), .RESP_COLLIDE(RESP_COLLIDE),
  .DATA_UPDATED(DATA_UPDATED), .OWN_ID(OWN_ID), .BUS_TX_DOM(BUS_TX_DOM),
  .SLEEPING(SLEEPING), .IGNORE_BUS(IGNORE_BUS), .RESPOND_EN(RESPOND_EN),
  .RESP_PID(RESP_PID), .POLL_SINGLE(POLL_SINGLE),
  .FRAME_CLASS(FRAME_CLASS), .EVT_VALID(EVT_VALID), .EVT_CODE(EVT_CODE),
  .GOTO_SLEEP_SEEN(GOTO_SLEEP_SEEN));

/* File: test/lsw_node.sv */
/* Other nodes on the single LIN wire, seen as one open-drain party.
   Assumes the device drives dominant while tx_dom is high. */
`timescale 1ns/10ps
module lsw_node (
  input logic clk,
  input logic tx_dom,
  output logic rx
);
  logic own_dom = 1'h0; // Far node pulling the wire low
  // Pull-up keeps the wire recessive unless a party drives
  assign rx = !(tx_dom || own_dom);
  // Remote wakeup: dominant for n clocks, changed off the edge
  task automatic wake(input int n);
    @(negedge clk) own_dom = 1'h1;
    repeat (n) @(negedge clk);
    own_dom = 1'h0;
  endtask
endmodule
